// ### design/pin_task_event_unit.sv
/*
  Pin task and event unit: eight channels binding tasks and events to
  pins, pin ownership muxing against the general-purpose port, and the
  multi-pin port event built from per-pin level watching.
  Assumes pins are asynchronous and are synchronised here; task pulses,
  configuration and software strobes are on clk.
*/
// Functional notes
// - Eight channels, each selects one pin.
// - Drive-high, clear and configurable tasks per channel.
// - Drive-high task sets pin high.
// - Clear task sets pin low.
// - Configurable task sets, clears or toggles.
// - Event on rising, falling or any edge.
// - Owned pins ignore general-purpose port output.
// - Disabled channel returns pin to port settings.
// - Priority: configurable, then clear, then high.
// - Polarity none with coincident task: no change.
// - Entering task mode loads initial level.
// - Event mode forces pin to input.
// - Task mode forces pin to output.
// - Port flag sets on combined sense rise.
// - Level watch: 0 off, 2 high, 3 low.
// - Remaining captured sense produces fresh rising edge.
// - Sense already high gives no idle wake.
// - Off request with sense high issues wakeup reset.
// - Port detection needs no clock request.
// - Write-one enable set; zero ignored; readable.
`timescale 1ns/100ps
module pin_task_event_unit #(
  parameter int CHANNELS = pte_pkg::NUM_CHANNELS,
  parameter int PINS = pte_pkg::NUM_PINS
) (
  input wire logic clk,
  input wire logic rst,
  input wire pte_pkg::chan_cfg_t [CHANNELS-1:0] chanCfg,
  input wire pte_pkg::pin_cfg_t [PINS-1:0] pinCfg,
  input wire logic [CHANNELS-1:0] taskDriveHigh,
  input wire logic [CHANNELS-1:0] taskClear,
  input wire logic [CHANNELS-1:0] taskConfigurable,
  input wire logic [PINS-1:0] portOut,
  input wire logic [PINS-1:0] portDir,
  input wire logic [PINS-1:0] pinIn,
  input wire logic latchMode,
  input wire logic [PINS-1:0] latchClear,
  input wire logic [CHANNELS-1:0] eventClear,
  input wire logic portEventClear,
  input wire logic [pte_pkg::NUM_IRQ-1:0] irq_enable_write_one,
  input wire logic [pte_pkg::NUM_IRQ-1:0] irq_disable_write_one,
  input wire logic idleRequest,
  input wire logic offRequest,
  output logic [PINS-1:0] pinOut,
  output logic [PINS-1:0] pinOe,
  output logic [CHANNELS-1:0] pinInputEvent,
  output logic multiPinEventFlag,
  output logic [pte_pkg::NUM_IRQ-1:0] irqEnable,
  output logic irq,
  output logic [PINS-1:0] senseCapture,
  output logic combinedSense,
  output logic idleWake,
  output logic offWakeReset
);
  import pte_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic [PINS-1:0] pinMeta;
  logic [PINS-1:0] pinSync;
  logic [PINS-1:0] pinPrev;
  logic [1:0] syncFill;
  logic [1:0] next_syncFill;
  logic syncReady;

  // The flops reset to zero whatever the pins show, so edges and levels
  // are ignored until real samples have reached the history flop.
  assign syncReady = (syncFill == SYNC_FILL_CYCLES);

  always_comb begin
    next_syncFill = syncReady ? syncFill : syncFill + 2'h1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinMeta <= '0;
      pinSync <= '0;
      pinPrev <= '0;
      syncFill <= '0;
    end else begin
      pinMeta <= pinIn;
      pinSync <= pinMeta;
      pinPrev <= pinSync;
      syncFill <= next_syncFill;
    end
  end

  // ----------------------------------------------------------------
  // Channel task state
  // ----------------------------------------------------------------
  logic [CHANNELS-1:0] taskLevel;
  logic [CHANNELS-1:0] next_taskLevel;
  logic [CHANNELS-1:0] wasTask;
  logic [CHANNELS-1:0] next_wasTask;
  logic [CHANNELS-1:0] next_pinInputEvent;

  always_comb begin
    next_taskLevel = taskLevel;
    next_wasTask = '0;
    next_pinInputEvent = pinInputEvent;
    for (int c = 0; c < CHANNELS; c++) begin
      logic cur;
      logic prev;
      cur = pinSync[chanCfg[c].pinSel];
      prev = pinPrev[chanCfg[c].pinSel];
      next_wasTask[c] = (chanCfg[c].mode == MODE_TASK);
      if (chanCfg[c].mode == MODE_TASK) begin
        if (!wasTask[c]) begin
          next_taskLevel[c] = chanCfg[c].taskInitialLevel;
        end else if (taskConfigurable[c]) begin
          case (chanCfg[c].polarity)
            POL_LO_TO_HI: next_taskLevel[c] = 1'b1;
            POL_HI_TO_LO: next_taskLevel[c] = 1'b0;
            POL_TOGGLE: next_taskLevel[c] = ~taskLevel[c];
            default: next_taskLevel[c] = taskLevel[c];
          endcase
        end else if (taskClear[c]) begin
          next_taskLevel[c] = 1'b0;
        end else if (taskDriveHigh[c]) begin
          next_taskLevel[c] = 1'b1;
        end
      end
      // The set wins over a software clear arriving in the same cycle.
      if (eventClear[c]) begin
        next_pinInputEvent[c] = 1'b0;
      end
      if (chanCfg[c].mode == MODE_EVENT && wasTask[c] == 1'b0 && syncReady) begin
        case (chanCfg[c].polarity)
          POL_LO_TO_HI: if (cur && !prev) next_pinInputEvent[c] = 1'b1;
          POL_HI_TO_LO: if (!cur && prev) next_pinInputEvent[c] = 1'b1;
          POL_TOGGLE: if (cur != prev) next_pinInputEvent[c] = 1'b1;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      taskLevel <= '0;
      wasTask <= '0;
      pinInputEvent <= EVENT_RESET;
    end else begin
      taskLevel <= next_taskLevel;
      wasTask <= next_wasTask;
      pinInputEvent <= next_pinInputEvent;
    end
  end

  // ----------------------------------------------------------------
  // Pin ownership mux
  // ----------------------------------------------------------------
  // Software must keep pin selects unique; with duplicates the highest
  // channel wins here, which is merely one arbitrary outcome.
  logic [PINS-1:0] next_pinOut;
  logic [PINS-1:0] next_pinOe;

  always_comb begin
    next_pinOut = portOut;
    next_pinOe = portDir;
    for (int c = 0; c < CHANNELS; c++) begin
      if (chanCfg[c].mode == MODE_TASK) begin
        next_pinOe[chanCfg[c].pinSel] = 1'b1;
        next_pinOut[chanCfg[c].pinSel] = wasTask[c] ? next_taskLevel[c]
                                                    : chanCfg[c].taskInitialLevel;
      end else if (chanCfg[c].mode == MODE_EVENT) begin
        next_pinOe[chanCfg[c].pinSel] = 1'b0;
        next_pinOut[chanCfg[c].pinSel] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinOut <= '0;
      pinOe <= '0;
    end else begin
      pinOut <= next_pinOut;
      pinOe <= next_pinOe;
    end
  end

  // ----------------------------------------------------------------
  // Level watch and combined sense
  // ----------------------------------------------------------------
  // Detection is pure logic on the already running system clock, so it
  // never asks for any extra clock to stay armed.
  logic [PINS-1:0] senseHit;
  logic [PINS-1:0] next_senseCapture;
  logic next_combinedSense;

  always_comb begin
    for (int p = 0; p < PINS; p++) begin
      case (pinCfg[p].levelWatch)
        WATCH_HIGH: senseHit[p] = pinSync[p];
        WATCH_LOW: senseHit[p] = ~pinSync[p];
        default: senseHit[p] = 1'b0;
      endcase
      if (!syncReady) begin
        senseHit[p] = 1'b0;
      end
    end
    next_senseCapture = (senseCapture & ~latchClear) | senseHit;
    // A partial clear drops the combined sense for one cycle when bits
    // remain, so a fresh rising edge follows.
    if (latchMode) begin
      next_combinedSense = (|latchClear) ? 1'b0 : (|next_senseCapture);
    end else begin
      next_combinedSense = |senseHit;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      senseCapture <= '0;
      combinedSense <= 1'b0;
    end else begin
      senseCapture <= next_senseCapture;
      combinedSense <= next_combinedSense;
    end
  end

  // ----------------------------------------------------------------
  // Port event, enables, interrupt and wake
  // ----------------------------------------------------------------
  logic senseRise;
  logic next_multiPinEventFlag;
  logic [NUM_IRQ-1:0] next_irqEnable;
  logic next_irq;
  logic next_idleWake;
  logic next_offWakeReset;
  logic senseAtIdle;
  logic next_senseAtIdle;

  assign senseRise = next_combinedSense & ~combinedSense;

  always_comb begin
    next_multiPinEventFlag = multiPinEventFlag & ~portEventClear;
    if (senseRise) begin
      next_multiPinEventFlag = 1'b1;
    end
    next_irqEnable = (irqEnable | irq_enable_write_one) & ~irq_disable_write_one;
    next_irq = |({next_multiPinEventFlag, next_pinInputEvent} & next_irqEnable);
    next_senseAtIdle = idleRequest ? (senseAtIdle | (combinedSense & ~idleWake)) : 1'b0;
    next_idleWake = idleRequest & senseRise & ~senseAtIdle;
    next_offWakeReset = offRequest & combinedSense;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      multiPinEventFlag <= 1'b0;
      irqEnable <= IRQ_EN_RESET;
      irq <= 1'b0;
      senseAtIdle <= 1'b0;
      idleWake <= 1'b0;
      offWakeReset <= 1'b0;
    end else begin
      multiPinEventFlag <= next_multiPinEventFlag;
      irqEnable <= next_irqEnable;
      irq <= next_irq;
      senseAtIdle <= next_senseAtIdle;
      idleWake <= next_idleWake;
      offWakeReset <= next_offWakeReset;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence clearOnlyOnCh0;
    chanCfg[0].mode == MODE_TASK && wasTask[0] && taskClear[0] && !taskConfigurable[0];
  endsequence

  chk_clear_drives_low: assert property (@(posedge clk) disable iff (rst)
    clearOnlyOnCh0 |=> !pinOut[$past(chanCfg[0].pinSel)])
    else $error("clear task did not drive low");
  chk_high_drives_high: assert property (@(posedge clk) disable iff (rst)
    chanCfg[0].mode == MODE_TASK && wasTask[0] && taskDriveHigh[0] && !taskClear[0]
    && !taskConfigurable[0] |=> taskLevel[0])
    else $error("drive-high task did not drive high");
  chk_toggle_inverts: assert property (@(posedge clk) disable iff (rst)
    chanCfg[0].mode == MODE_TASK && wasTask[0] && taskConfigurable[0]
    && chanCfg[0].polarity == POL_TOGGLE |=> taskLevel[0] != $past(taskLevel[0]))
    else $error("toggle task did not invert");
  chk_none_holds: assert property (@(posedge clk) disable iff (rst)
    chanCfg[0].mode == MODE_TASK && wasTask[0] && taskConfigurable[0]
    && chanCfg[0].polarity == POL_NONE |=> $stable(taskLevel[0]))
    else $error("polarity none changed level");
  chk_task_entry_level: assert property (@(posedge clk) disable iff (rst)
    chanCfg[0].mode == MODE_TASK && !wasTask[0]
    |=> taskLevel[0] == $past(chanCfg[0].taskInitialLevel))
    else $error("task entry level wrong");
  chk_event_forces_input: assert property (@(posedge clk) disable iff (rst)
    chanCfg[1].mode == MODE_EVENT |=> !pinOe[$past(chanCfg[1].pinSel)])
    else $error("event mode pin not input");
  chk_port_flag_rise: assert property (@(posedge clk) disable iff (rst)
    $rose(combinedSense) |-> multiPinEventFlag)
    else $error("port flag missed sense rise");
  chk_event_sticky: assert property (@(posedge clk) disable iff (rst)
    pinInputEvent[1] && !eventClear[1] |=> pinInputEvent[1])
    else $error("event flag dropped without clear");
  chk_enable_write_one: assert property (@(posedge clk) disable iff (rst)
    irq_enable_write_one[1] && !irq_disable_write_one[1] |=> irqEnable[1])
    else $error("enable set ignored");
  chk_off_wake: assert property (@(posedge clk) disable iff (rst)
    offRequest && combinedSense |=> offWakeReset)
    else $error("no wakeup reset from off");
endmodule

// ### pkg/pte_pkg.sv
/*
  Package for the pin task and event unit: channel count, pin count,
  mode, polarity and level-watch encodings, reset values, and the packed
  channel configuration carrier.
  Assumes a single 10 MHz system clock domain.
*/
package pte_pkg;
  localparam int NUM_CHANNELS = 8;
  localparam int NUM_PINS = 32;
  localparam int PIN_SEL_W = 5;
  localparam int NUM_IRQ = NUM_CHANNELS + 1;
  localparam int PORT_IRQ_BIT = NUM_CHANNELS;

  localparam logic [1:0] MODE_DISABLED = 2'h0;
  localparam logic [1:0] MODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_TASK = 2'h3;

  localparam logic [1:0] POL_NONE = 2'h0;
  localparam logic [1:0] POL_LO_TO_HI = 2'h1;
  localparam logic [1:0] POL_HI_TO_LO = 2'h2;
  localparam logic [1:0] POL_TOGGLE = 2'h3;

  localparam logic [1:0] WATCH_DISABLED = 2'h0;
  localparam logic [1:0] WATCH_HIGH = 2'h2;
  localparam logic [1:0] WATCH_LOW = 2'h3;

  localparam logic [NUM_IRQ-1:0] IRQ_EN_RESET = 9'h000;
  localparam logic [NUM_CHANNELS-1:0] EVENT_RESET = 8'h00;
  localparam logic [1:0] SYNC_FILL_CYCLES = 2'h3;

  typedef struct packed {
    logic [1:0] mode;
    logic [PIN_SEL_W-1:0] pinSel;
    logic [1:0] polarity;
    logic taskInitialLevel;
  } chan_cfg_t;

  typedef struct packed {
    logic [1:0] levelWatch;
  } pin_cfg_t;
endpackage

// ### test/pin_model.sv
/*
  Far side of the pin task and event unit: the external pins.
  Assumes the bench sets the level that the outside world puts on each pin.
*/
`timescale 1ns/100ps
module pin_model #(
  parameter int PINS = pte_pkg::NUM_PINS
) (
  input wire logic [PINS-1:0] pinOut,
  input wire logic [PINS-1:0] pinOe,
  input wire logic [PINS-1:0] extLevel,
  output logic [PINS-1:0] pinIn
);
  // ----------------------------------------
  // Pin wire level
  // ----------------------------------------
  // A driven pin reads back its own driver, so a faulty enable shows up as
  // a missing or spurious event rather than passing unseen.
  assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule

// ### test/pin_task_event_channels_tb_top.sv
/*
  Self-checking bench for the pin task and event unit.
  Assumes the pin model as far side and default unit parameters.
*/
`timescale 1ns/100ps
module pin_task_event_channels_tb_top;
  import pte_pkg::*;
  typedef struct packed {
    logic [2:0] t;
    logic [1:0] pol;
    logic exp;
  } row_t;
  logic clk, rst, latchMode, portEventClear, idleRequest, offRequest;
  chan_cfg_t [NUM_CHANNELS-1:0] chanCfg;
  pin_cfg_t [NUM_PINS-1:0] pinCfg;
  logic [NUM_CHANNELS-1:0] taskDriveHigh, taskClear, taskConfigurable;
  logic [NUM_CHANNELS-1:0] eventClear, pinInputEvent;
  logic [NUM_PINS-1:0] portOut, portDir, pinIn, latchClear, ext;
  logic [NUM_PINS-1:0] pinOut, pinOe, senseCapture;
  logic [NUM_IRQ-1:0] irqSet, irqClr, irqEnable;
  logic multiPinEventFlag, irq, combinedSense, idleWake, offWakeReset;
  int n_fail, checked, cycles, i, k;
  // Each row is {configurable, clear, high}, polarity, expected pin.
  row_t rows [10] = '{'{3'h2, POL_NONE, 1'h0}, '{3'h1, POL_NONE, 1'h1},
    '{3'h4, POL_HI_TO_LO, 1'h0}, '{3'h4, POL_LO_TO_HI, 1'h1},
    '{3'h4, POL_TOGGLE, 1'h0}, '{3'h4, POL_TOGGLE, 1'h1},
    '{3'h7, POL_NONE, 1'h1}, '{3'h3, POL_NONE, 1'h0},
    '{3'h6, POL_LO_TO_HI, 1'h1}, '{3'h5, POL_HI_TO_LO, 1'h0}};

  pin_task_event_unit uut (.clk(clk), .rst(rst), .chanCfg(chanCfg), .pinCfg(pinCfg),
    .taskDriveHigh(taskDriveHigh), .taskClear(taskClear),
    .taskConfigurable(taskConfigurable), .portOut(portOut), .portDir(portDir),
    .pinIn(pinIn), .latchMode(latchMode), .latchClear(latchClear),
    .eventClear(eventClear), .portEventClear(portEventClear),
    .irq_enable_write_one(irqSet), .irq_disable_write_one(irqClr),
    .idleRequest(idleRequest), .offRequest(offRequest), .pinOut(pinOut),
    .pinOe(pinOe), .pinInputEvent(pinInputEvent),
    .multiPinEventFlag(multiPinEventFlag), .irqEnable(irqEnable), .irq(irq),
    .senseCapture(senseCapture), .combinedSense(combinedSense),
    .idleWake(idleWake), .offWakeReset(offWakeReset));
  pin_model model (.pinOut(pinOut), .pinOe(pinOe), .extLevel(ext), .pinIn(pinIn));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Port sources are rearmed with the port interrupt masked meanwhile.
  task automatic arm(input logic [1:0] w);
    irqClr = 9'h100;
    step(1);
    irqClr = '0;
    pinCfg[10].levelWatch = w;
    portEventClear = 1'h1;
    step(1);
    portEventClear = 1'h0;
    irqSet = 9'h100;
    step(1);
    irqSet = '0;
  endtask

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      n_fail++;
      complete_run();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst, latchMode, portEventClear, idleRequest, offRequest} = 5'h10;
    {chanCfg, pinCfg, taskDriveHigh, taskClear, taskConfigurable} = '0;
    {eventClear, latchClear, ext, irqSet, irqClr, portDir} = '0;
    portOut = 32'hFFFFFFFF;
    step(10);
    rst = 1'h0;
    step(1);
    // A task on the first task-mode cycle is ignored by design choice.
    chanCfg[0] = {MODE_TASK, 5'h03, POL_NONE, 1'h0};
    taskDriveHigh[0] = 1'h1;
    step(1);
    taskDriveHigh = '0;
    check(pinOut[3], 1'h0);
    for (i = 0; i < 10; i++) begin
      {taskConfigurable[0], taskClear[0], taskDriveHigh[0]} = rows[i].t;
      chanCfg[0].polarity = rows[i].pol;
      step(1);
      {taskConfigurable, taskClear, taskDriveHigh} = '0;
      check(pinOut[3], rows[i].exp);
      check(pinOe[3], 1'h1);
    end
    chanCfg[0].mode = MODE_DISABLED;
    taskClear[0] = 1'h1;
    step(1);
    taskClear = '0;
    check({pinOe[3], pinOut[3]}, 2'h1);
    chanCfg[1] = {MODE_EVENT, 5'h05, POL_LO_TO_HI, 1'h0};
    portDir = 32'h00000020;
    irqSet = 9'h002;
    step(1);
    irqSet = '0;
    check(irqEnable, 9'h002);
    check(pinOe[5], 1'h0);
    for (i = 1; i < 4; i++) begin
      chanCfg[1].polarity = i[1:0];
      eventClear[1] = 1'h1;
      step(1);
      eventClear = '0;
      ext[5] = 1'h1;
      step(3);
      check(pinInputEvent[1], i != 2);
      check(irq, i != 2);
      eventClear[1] = 1'h1;
      step(1);
      eventClear = '0;
      ext[5] = 1'h0;
      step(3);
      check(pinInputEvent[1], i != 1);
    end
    irqClr = 9'h002;
    step(1);
    irqClr = '0;
    check({irqEnable, irq, pinInputEvent[1]}, 11'h001);
    arm(WATCH_HIGH);
    ext[10] = 1'h1;
    step(3);
    check({combinedSense, multiPinEventFlag, irq}, 3'h7);
    idleRequest = 1'h1;
    step(2);
    idleRequest = 1'h0;
    check(idleWake, 1'h0);
    offRequest = 1'h1;
    step(1);
    offRequest = 1'h0;
    check(offWakeReset, 1'h1);
    arm(WATCH_DISABLED);
    step(3);
    check(combinedSense, 1'h0);
    idleRequest = 1'h1;
    ext[10] = 1'h0;
    arm(WATCH_LOW);
    check(idleWake, 1'h1);
    idleRequest = 1'h0;
    step(3);
    check({combinedSense, multiPinEventFlag}, 2'h3);
    latchMode = 1'h1;
    step(4);
    check(senseCapture[10], 1'h1);
    portEventClear = 1'h1;
    step(1);
    portEventClear = 1'h0;
    check(multiPinEventFlag, 1'h0);
    latchClear[10] = 1'h1;
    step(1);
    latchClear = '0;
    for (k = 0; k < 8 && multiPinEventFlag !== 1'h1; k++) begin
      step(1);
    end
    check(multiPinEventFlag, 1'h1);
    rst = 1'h1;
    step(1);
    check(pinOe, '0);
    check({irqEnable, pinInputEvent, multiPinEventFlag}, '0);
    rst = 1'h0;
    step(1);
    complete_run();
  end
endmodule
